// File: shared/pmc_pkg.sv
// Purpose: shared constants and types for the message element checker ends
// Assumes: one element code per slot, codes are local encodings
// Notes:   element and message codes are arbitrary local numbering
package pmc_pkg;
    localparam int MSG_W  = 3;
    localparam int IE_W   = 5;
    localparam int SEQ_W  = 4;
    localparam int PAR_W  = 3;
    localparam int MAXIE  = 4;
    localparam int CNT_W  = 3;

    typedef enum logic [MSG_W-1:0] {
        MSG_ESTABLISH, MSG_ESTABLISH_ACK, MSG_SIGNAL, MSG_DISCONNECT,
        MSG_DISC_COMPLETE, MSG_PROTOCOL_PARAM, MSG_OTHER
    } pmc_msg_t;

    typedef enum logic [IE_W-1:0] {
        IE_LINE_INFO, IE_PULSE_NOTIFY, IE_AUTO_SEQ, IE_SEQ_RESP, IE_CAD_RING,
        IE_PULSED, IE_STEADY, IE_DIGIT, IE_RES_UNAVAIL, IE_EN_METER,
        IE_METER_REPORT, IE_ATTEN, IE_RECOG_TIME, IE_EN_AUTO_ACK, IE_DIS_AUTO_ACK
    } pmc_ie_t;

    typedef enum logic [1:0] {PATH_NULL, PATH_EST, PATH_ACTIVE, PATH_DISC} pmc_path_t;

    localparam logic [PAR_W-1:0] LI_IMP_RESET   = 3'h0;
    localparam logic [PAR_W-1:0] LI_IMP_SET     = 3'h1;
    localparam logic [PAR_W-1:0] LI_LOW_LOOP    = 3'h2;
    localparam logic [PAR_W-1:0] LI_ANOM_LOOP   = 3'h3;
    localparam logic [PAR_W-1:0] LI_ANOM_LINE   = 3'h4;
    localparam logic [PAR_W-1:0] LI_NUM_PARAMS  = 3'h5;
    localparam logic [7:0]       PULSE_NOTE_VAL = 8'h00;

    // direction: 1 = from exchange to access node side
    function automatic logic ieAllowed(input pmc_msg_t m, input pmc_ie_t e, input logic fromEx);
        logic ok;
        ok = 1'b0;
        case (m)
            MSG_ESTABLISH:      ok = e inside {IE_LINE_INFO, IE_AUTO_SEQ, IE_CAD_RING, IE_PULSED, IE_STEADY};
            MSG_ESTABLISH_ACK:  ok = e inside {IE_AUTO_SEQ, IE_PULSED, IE_STEADY};
            MSG_SIGNAL:         ok = (e != IE_LINE_INFO) && (e <= IE_ATTEN);
            MSG_DISCONNECT:     ok = (e == IE_STEADY);
            MSG_DISC_COMPLETE:  ok = (e == IE_STEADY);
            MSG_PROTOCOL_PARAM: ok = e inside {IE_RECOG_TIME, IE_EN_AUTO_ACK, IE_DIS_AUTO_ACK};
            default:            ok = 1'b0;
        endcase
        if (e == IE_AUTO_SEQ && !fromEx)
            ok = 1'b0;
        if (e == IE_SEQ_RESP && fromEx)
            ok = 1'b0;
        return ok;
    endfunction
endpackage

// File: shared/pmc_link_if.sv
// Purpose: message transfer between exchange end and access node side end
// Assumes: single cycle valid strobes, element list held with valid
// Notes:   dnData and upData carry a parameter or sequence type per element
`timescale 1ns/1ns
interface pmc_link_if;
    logic                                          dnValid;
    pmc_pkg::pmc_msg_t                             dnMsg;
    logic [pmc_pkg::CNT_W-1:0]                     dnCount;
    pmc_pkg::pmc_ie_t [pmc_pkg::MAXIE-1:0]         dnIe;
    logic [pmc_pkg::MAXIE-1:0][7:0]                dnData;
    logic                                          upValid;
    pmc_pkg::pmc_msg_t                             upMsg;
    logic [pmc_pkg::CNT_W-1:0]                     upCount;
    pmc_pkg::pmc_ie_t                              upIe;
    logic [7:0]                                    upData;

    modport exch (output dnValid, dnMsg, dnCount, dnIe, dnData,
                  input  upValid, upMsg, upCount, upIe, upData);
    modport node (input  dnValid, dnMsg, dnCount, dnIe, dnData,
                  output upValid, upMsg, upCount, upIe, upData);
endinterface

// File: rtl/pmc_exch_end.sv
// Purpose: exchange end, sends checked messages and checks received ones
// Assumes: user asks with a one-cycle request, one element per send
// Notes:   illegal user requests are dropped and flagged
`timescale 1ns/1ns
module pmc_exch_end (
    // clock and reset
    input  wire logic                      core_clk,
    input  wire logic                      sys_rst,
    // link
    pmc_link_if.exch                       link,
    // user request
    input  wire logic                      txReq,
    input  wire pmc_pkg::pmc_msg_t         txMsg,
    input  wire logic                      txHasIe,
    input  wire pmc_pkg::pmc_ie_t          txIe,
    input  wire logic [7:0]                txData,
    input  wire logic                      pathActive,
    // user results
    output logic                           txReject,
    output logic                           rxValid,
    output pmc_pkg::pmc_msg_t              rxMsg,
    output logic                           rxHasIe,
    output pmc_pkg::pmc_ie_t               rxIe,
    output logic [7:0]                     rxData,
    output logic                           rxError
);
    typedef struct packed {
        logic                  dnValid;
        pmc_pkg::pmc_msg_t     dnMsg;
        logic [pmc_pkg::CNT_W-1:0] dnCount;
        pmc_pkg::pmc_ie_t      dnIe;
        logic [7:0]            dnData;
        logic                  txReject;
        logic                  rxValid;
        pmc_pkg::pmc_msg_t     rxMsg;
        logic                  rxHasIe;
        pmc_pkg::pmc_ie_t      rxIe;
        logic [7:0]            rxData;
        logic                  rxError;
    } pmc_exst_t;

    pmc_exst_t st_q;
    pmc_exst_t st_d;

    always_comb begin
        logic ok;
        ok = 1'b1;
        st_d = st_q;
        st_d.dnValid = 1'b0;
        st_d.txReject = 1'b0;
        st_d.rxValid = 1'b0;
        st_d.rxError = 1'b0;
        if (txReq) begin
            if (txHasIe && !pmc_pkg::ieAllowed(txMsg, txIe, 1'b1))
                ok = 1'b0; // [RULE_02] [RULE_03] [RULE_04] [RULE_05] [RULE_07] [RULE_09] [RULE_16] [RULE_19]
            if (txMsg == pmc_pkg::MSG_PROTOCOL_PARAM && !pathActive)
                ok = 1'b0; // [RULE_10]
            if (txHasIe && txIe == pmc_pkg::IE_AUTO_SEQ && !pathActive && txMsg == pmc_pkg::MSG_SIGNAL)
                ok = 1'b0; // [RULE_18]
            if (txHasIe && txIe == pmc_pkg::IE_LINE_INFO && txData >= 8'(pmc_pkg::LI_NUM_PARAMS))
                ok = 1'b0; // [RULE_13]
            st_d.txReject = !ok;
            st_d.dnValid = ok;
            st_d.dnMsg = txMsg;
            st_d.dnCount = (ok && txHasIe) ? 3'h1 : 3'h0; // [RULE_01] [RULE_12]
            st_d.dnIe = txIe;
            st_d.dnData = txData;
        end
        if (link.upValid) begin
            ok = (link.upCount <= 3'h1); // [RULE_01]
            if (link.upCount != 3'h0 && !pmc_pkg::ieAllowed(link.upMsg, link.upIe, 1'b0))
                ok = 1'b0; // [RULE_16] [RULE_19]
            if (link.upMsg == pmc_pkg::MSG_PROTOCOL_PARAM && !pathActive)
                ok = 1'b0; // [RULE_10]
            st_d.rxValid = 1'b1;
            st_d.rxMsg = link.upMsg;
            st_d.rxHasIe = ok && link.upCount != 3'h0; // [RULE_12]
            st_d.rxIe = link.upIe;
            st_d.rxData = link.upData;
            st_d.rxError = !ok;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign link.dnValid = st_q.dnValid;
    assign link.dnMsg   = st_q.dnMsg;
    assign link.dnCount = st_q.dnCount;
    assign link.dnIe    = '{0: st_q.dnIe, default: pmc_pkg::IE_LINE_INFO};
    assign link.dnData  = '{0: st_q.dnData, default: 8'h00};
    assign txReject = st_q.txReject;
    assign rxValid  = st_q.rxValid;
    assign rxMsg    = st_q.rxMsg;
    assign rxHasIe  = st_q.rxHasIe;
    assign rxIe     = st_q.rxIe;
    assign rxData   = st_q.rxData;
    assign rxError  = st_q.rxError;
endmodule

// File: rtl/pmc_node_end.sv
// Purpose: access node side end, checks exchange messages, acts on elements
// Assumes: one port; path state driven by received messages
// Notes:   parameter changes apply silently, no confirmation is returned
`timescale 1ns/1ns
//
// Behaviour
// RULE_01: one element per message, protocol parameter excepted
// RULE_02: establish allows line, sequence, ringing, pulsed, steady
// RULE_03: establish ack allows sequence, pulsed, steady
// RULE_04: signal allows everything except line information; code also refuses recognition time and ack enable/disable in signal
// RULE_05: disconnect carries steady signal only
// RULE_06: steady in disconnect deactivates port, reports status
// RULE_07: disconnect complete carries steady signal only
// RULE_08: steady in disconnect complete applied to line
// RULE_09: protocol parameter allows recognition time, ack enables
// RULE_10: protocol parameter only in path active
// RULE_11: no confirmation after parameter change
// RULE_12: no default element; absent means none
// RULE_13: line information holds one of five parameters
// RULE_14: anomalous line condition reported to request path
// RULE_15: pulse notification single value on pulse events
// RULE_16: autonomous sequence only exchange to node side
// RULE_17: sequence type starts predefined autonomous sequence
// RULE_18: no autonomous sequence pre-arming in null state
// RULE_19: sequence response only node side to exchange
// RULE_20: illegal element flagged as error and ignored
// RULE_21: path state checked before forwarding protocol parameter
module pmc_node_end (
    // clock and reset
    input  wire logic                      core_clk,
    input  wire logic                      sys_rst,
    // link
    pmc_link_if.node                       link,
    // line events from port logic
    input  wire logic                      pulseEvent,
    input  wire logic                      anomLine,
    input  wire logic                      lineInfoReq,
    input  wire logic [pmc_pkg::PAR_W-1:0] lineInfoPar,
    input  wire logic                      portStatusReq,
    input  wire logic [7:0]                portStatus,
    // port actions
    output logic                           portDeactivate,
    output logic                           applySteady,
    output logic [7:0]                     steadyCode,
    output logic                           seqStart,
    output logic [pmc_pkg::SEQ_W-1:0]      seqType,
    output logic                           paramValid,
    output pmc_pkg::pmc_ie_t               paramIe,
    output logic [7:0]                     paramData,
    output logic                           sigValid,
    output pmc_pkg::pmc_ie_t               sigIe,
    output logic [7:0]                     sigData,
    output logic                           protoError,
    output pmc_pkg::pmc_path_t             pathState
);
    typedef struct packed {
        pmc_pkg::pmc_path_t    path;
        logic                  upValid;
        pmc_pkg::pmc_msg_t     upMsg;
        logic [pmc_pkg::CNT_W-1:0] upCount;
        pmc_pkg::pmc_ie_t      upIe;
        logic [7:0]            upData;
        logic                  portDeactivate;
        logic                  applySteady;
        logic [7:0]            steadyCode;
        logic                  seqStart;
        logic [pmc_pkg::SEQ_W-1:0] seqType;
        logic                  paramValid;
        pmc_pkg::pmc_ie_t      paramIe;
        logic [7:0]            paramData;
        logic                  sigValid;
        pmc_pkg::pmc_ie_t      sigIe;
        logic [7:0]            sigData;
        logic                  protoError;
    } pmc_ndst_t;

    pmc_ndst_t st_q;
    pmc_ndst_t st_d;

    always_comb begin
        logic              ok;
        pmc_pkg::pmc_ie_t  e;
        logic [7:0]        dat;

        ok = 1'b1;
        e = link.dnIe[0];
        dat = link.dnData[0];

        st_d = st_q;

        st_d.upValid = 1'b0;
        st_d.portDeactivate = 1'b0;
        st_d.applySteady = 1'b0;
        st_d.seqStart = 1'b0;
        st_d.paramValid = 1'b0;
        st_d.sigValid = 1'b0;
        st_d.protoError = 1'b0;

        // replies to the exchange, one per cycle; only the event with priority is sent, the others in that cycle are dropped
        if (anomLine) begin
            st_d.upValid = 1'b1; // [RULE_14]
            st_d.upMsg = pmc_pkg::MSG_ESTABLISH;
            st_d.upCount = 3'h1;
            st_d.upIe = pmc_pkg::IE_LINE_INFO;
            st_d.upData = {5'h00, pmc_pkg::LI_ANOM_LINE};
        end else if (lineInfoReq && lineInfoPar < pmc_pkg::LI_NUM_PARAMS) begin
            st_d.upValid = 1'b1; // [RULE_13]
            st_d.upMsg = pmc_pkg::MSG_ESTABLISH;
            st_d.upCount = 3'h1;
            st_d.upIe = pmc_pkg::IE_LINE_INFO;
            st_d.upData = {5'h00, lineInfoPar};
        end else if (pulseEvent) begin
            st_d.upValid = 1'b1; // [RULE_15]
            st_d.upMsg = pmc_pkg::MSG_SIGNAL;
            st_d.upCount = 3'h1;
            st_d.upIe = pmc_pkg::IE_PULSE_NOTIFY;
            st_d.upData = pmc_pkg::PULSE_NOTE_VAL;
        end else if (portStatusReq) begin
            st_d.upValid = 1'b1; // [RULE_06]
            st_d.upMsg = pmc_pkg::MSG_DISCONNECT;
            st_d.upCount = 3'h1;
            st_d.upIe = pmc_pkg::IE_STEADY;
            st_d.upData = portStatus;
        end

        if (link.dnValid) begin
            if (link.dnMsg != pmc_pkg::MSG_PROTOCOL_PARAM && link.dnCount > 3'h1)
                ok = 1'b0; // [RULE_01] [RULE_20]

            for (int i = 1; i < pmc_pkg::MAXIE; i++)
                if (i < int'(link.dnCount) && !pmc_pkg::ieAllowed(link.dnMsg, link.dnIe[i], 1'b1))
                    ok = 1'b0; // [RULE_09]

            if (link.dnCount != 3'h0 && !pmc_pkg::ieAllowed(link.dnMsg, e, 1'b1))
                ok = 1'b0; // [RULE_02] [RULE_03] [RULE_04] [RULE_05] [RULE_07] [RULE_09] [RULE_16] [RULE_20]

            if (link.dnMsg == pmc_pkg::MSG_PROTOCOL_PARAM && st_q.path != pmc_pkg::PATH_ACTIVE)
                ok = 1'b0; // [RULE_10] [RULE_21]

            if (link.dnCount != 3'h0 && e == pmc_pkg::IE_AUTO_SEQ && st_q.path == pmc_pkg::PATH_NULL
                && link.dnMsg == pmc_pkg::MSG_SIGNAL)
                ok = 1'b0; // [RULE_18]

            st_d.protoError = !ok; // [RULE_20]

            case (link.dnMsg)
                pmc_pkg::MSG_ESTABLISH:     st_d.path = pmc_pkg::PATH_EST;
                pmc_pkg::MSG_ESTABLISH_ACK: st_d.path = pmc_pkg::PATH_ACTIVE;
                pmc_pkg::MSG_DISCONNECT:    st_d.path = pmc_pkg::PATH_DISC;
                pmc_pkg::MSG_DISC_COMPLETE: st_d.path = pmc_pkg::PATH_NULL;
                default:                    st_d.path = st_q.path;
            endcase

            if (link.dnMsg == pmc_pkg::MSG_ESTABLISH && st_q.path == pmc_pkg::PATH_NULL)
                st_d.path = pmc_pkg::PATH_ACTIVE;

            if (link.dnMsg == pmc_pkg::MSG_DISCONNECT)
                st_d.portDeactivate = ok && link.dnCount != 3'h0; // [RULE_06] [RULE_12]

            if (ok && link.dnCount != 3'h0) begin
                if (link.dnMsg == pmc_pkg::MSG_PROTOCOL_PARAM) begin
                    // several elements allowed, only the first slot is forwarded here
                    st_d.paramValid = 1'b1; // [RULE_01] [RULE_11] [RULE_21]
                    st_d.paramIe = e;
                    st_d.paramData = dat;
                end else if (link.dnMsg == pmc_pkg::MSG_DISC_COMPLETE) begin
                    st_d.applySteady = 1'b1; // [RULE_08]
                    st_d.steadyCode = dat;
                end else if (e == pmc_pkg::IE_AUTO_SEQ) begin
                    st_d.seqStart = 1'b1; // [RULE_17]
                    st_d.seqType = dat[pmc_pkg::SEQ_W-1:0];
                end else if (link.dnMsg != pmc_pkg::MSG_DISCONNECT) begin
                    st_d.sigValid = 1'b1;
                    st_d.sigIe = e;
                    st_d.sigData = dat;
                end
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign link.upValid   = st_q.upValid;
    assign link.upMsg     = st_q.upMsg;
    assign link.upCount   = st_q.upCount;
    assign link.upIe      = st_q.upIe;
    assign link.upData    = st_q.upData;

    assign portDeactivate = st_q.portDeactivate;
    assign applySteady    = st_q.applySteady;
    assign steadyCode     = st_q.steadyCode;
    assign seqStart       = st_q.seqStart;
    assign seqType        = st_q.seqType;
    assign paramValid     = st_q.paramValid;
    assign paramIe        = st_q.paramIe;
    assign paramData      = st_q.paramData;
    assign sigValid       = st_q.sigValid;
    assign sigIe          = st_q.sigIe;
    assign sigData        = st_q.sigData;
    assign protoError     = st_q.protoError;
    assign pathState      = st_q.path;
endmodule

// File: verification/pmc_link_chk.sv
// Purpose: element placement checks on the link between both ends
// Assumes: only slot 0 of the downstream list is meaningful
// Notes:   sees only link signals, so port actions are judged by the bench
`timescale 1ns/1ns
module pmc_link_chk (
    // clock and reset
    input wire logic                                  core_clk,
    input wire logic                                  sys_rst,
    // downstream
    input wire logic                                  dnValid,
    input wire pmc_pkg::pmc_msg_t                     dnMsg,
    input wire logic [pmc_pkg::CNT_W-1:0]             dnCount,
    input wire pmc_pkg::pmc_ie_t [pmc_pkg::MAXIE-1:0] dnIe,
    input wire logic [pmc_pkg::MAXIE-1:0][7:0]        dnData,
    // upstream
    input wire logic                                  upValid,
    input wire pmc_pkg::pmc_msg_t                     upMsg,
    input wire logic [pmc_pkg::CNT_W-1:0]             upCount,
    input wire pmc_pkg::pmc_ie_t                      upIe,
    input wire logic [7:0]                            upData
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    wire dnHas = dnValid && (dnCount != 3'h0);
    wire upHas = upValid && (upCount != 3'h0);

    a_dn_one_elem: assert property (dnValid && dnMsg != pmc_pkg::MSG_PROTOCOL_PARAM |-> dnCount <= 3'h1)
        else $error("downstream message with several elements");
    a_up_one_elem: assert property (upValid |-> upCount <= 3'h1)
        else $error("upstream message with several elements");
    a_est_set: assert property (dnHas && dnMsg == pmc_pkg::MSG_ESTABLISH |-> dnIe[0] inside {pmc_pkg::IE_LINE_INFO,
        pmc_pkg::IE_AUTO_SEQ, pmc_pkg::IE_CAD_RING, pmc_pkg::IE_PULSED, pmc_pkg::IE_STEADY})
        else $error("element not allowed in establish");
    a_ack_set: assert property (dnHas && dnMsg == pmc_pkg::MSG_ESTABLISH_ACK |->
        dnIe[0] inside {pmc_pkg::IE_AUTO_SEQ, pmc_pkg::IE_PULSED, pmc_pkg::IE_STEADY})
        else $error("element not allowed in establish ack");
    a_sig_no_line: assert property (dnHas && dnMsg == pmc_pkg::MSG_SIGNAL |-> dnIe[0] != pmc_pkg::IE_LINE_INFO)
        else $error("line information in signal");
    a_disc_steady: assert property ((dnHas && dnMsg == pmc_pkg::MSG_DISCONNECT |-> dnIe[0] == pmc_pkg::IE_STEADY)
        and (upHas && upMsg == pmc_pkg::MSG_DISCONNECT |-> upIe == pmc_pkg::IE_STEADY))
        else $error("disconnect carries other than steady");
    a_dc_steady: assert property (dnHas && dnMsg == pmc_pkg::MSG_DISC_COMPLETE |-> dnIe[0] == pmc_pkg::IE_STEADY)
        else $error("disconnect complete carries other than steady");
    a_pp_set: assert property (dnValid && dnMsg == pmc_pkg::MSG_PROTOCOL_PARAM && dnCount != 3'h0 |->
        dnIe[0] inside {pmc_pkg::IE_RECOG_TIME, pmc_pkg::IE_EN_AUTO_ACK, pmc_pkg::IE_DIS_AUTO_ACK})
        else $error("element not allowed in protocol parameter");
    a_seq_dir: assert property (upHas |-> upIe != pmc_pkg::IE_AUTO_SEQ)
        else $error("autonomous sequence sent upstream");
    a_resp_dir: assert property (dnHas |-> dnIe[0] != pmc_pkg::IE_SEQ_RESP)
        else $error("sequence response sent downstream");
    a_pulse_val: assert property (upHas && upIe == pmc_pkg::IE_PULSE_NOTIFY |-> upData == pmc_pkg::PULSE_NOTE_VAL)
        else $error("pulse notification value wrong");
    a_line_par: assert property (upHas && upIe == pmc_pkg::IE_LINE_INFO |-> upData < 8'h05)
        else $error("line information parameter out of range");
endmodule

// File: verification/pstn_message_element_checker_test.sv
// Purpose: drives both ends through their user sides and a faulty link
// Assumes: second node end faces the bench, which breaks the rules on purpose
// Notes:   node pulses stand one cycle, so they are looked at right after send
`timescale 1ns/1ns
module pstn_message_element_checker_test;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic txReq = 1'b0, txHasIe = 1'b0, pathActive = 1'b0;
    pmc_pkg::pmc_msg_t txMsg = pmc_pkg::MSG_OTHER;
    pmc_pkg::pmc_ie_t txIe = pmc_pkg::IE_LINE_INFO;
    logic [7:0] txData = 8'h00, portStatus = 8'h00, steadyCode, rxData, paramData, sigData;
    logic pulseEvent = 1'b0, anomLine = 1'b0, lineInfoReq = 1'b0, portStatusReq = 1'b0;
    logic [2:0] lineInfoPar = 3'h0;
    logic txReject, rxValid, rxHasIe, rxError, portDeactivate, applySteady, seqStart, paramValid, sigValid;
    logic protoError, protoError2;
    logic [3:0] seqType;
    pmc_pkg::pmc_msg_t rxMsg;
    pmc_pkg::pmc_ie_t rxIe, paramIe, sigIe;
    pmc_pkg::pmc_path_t pathState;
    pmc_pkg::pmc_ie_t pp[3] = '{pmc_pkg::IE_RECOG_TIME, pmc_pkg::IE_EN_AUTO_ACK, pmc_pkg::IE_DIS_AUTO_ACK};
    int miscompares = 0, checksDone = 0, cycles = 0;

    pmc_link_if link();
    pmc_link_if link2();
    pmc_exch_end pmc_exch_end_inst (.core_clk, .sys_rst, .link(link), .txReq, .txMsg, .txHasIe, .txIe, .txData,
        .pathActive, .txReject, .rxValid, .rxMsg, .rxHasIe, .rxIe, .rxData, .rxError);
    pmc_node_end pmc_node_end_inst (.core_clk, .sys_rst, .link(link), .pulseEvent, .anomLine, .lineInfoReq,
        .lineInfoPar, .portStatusReq, .portStatus, .portDeactivate, .applySteady, .steadyCode, .seqStart, .seqType,
        .paramValid, .paramIe, .paramData, .sigValid, .sigIe, .sigData, .protoError, .pathState);
    pmc_node_end pmc_node_end_inst2 (.core_clk, .sys_rst, .link(link2), .pulseEvent, .anomLine, .lineInfoReq,
        .lineInfoPar, .portStatusReq, .portStatus, .portDeactivate(), .applySteady(), .steadyCode(), .seqStart(),
        .seqType(), .paramValid(), .paramIe(), .paramData(), .sigValid(), .sigIe(), .sigData(),
        .protoError(protoError2), .pathState());
    pmc_link_chk pmc_link_chk_inst (.core_clk, .sys_rst, .dnValid(link.dnValid), .dnMsg(link.dnMsg),
        .dnCount(link.dnCount), .dnIe(link.dnIe), .dnData(link.dnData), .upValid(link.upValid), .upMsg(link.upMsg),
        .upCount(link.upCount), .upIe(link.upIe), .upData(link.upData));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checksDone++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("checks=%0d miscompares=%0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // one user request; on return the node answer of this request stands
    task automatic send(input pmc_pkg::pmc_msg_t m, input logic h, input pmc_pkg::pmc_ie_t e, input logic [7:0] d,
                        input logic pa, input logic rj);
        @(posedge core_clk);
        txReq <= 1'b1;
        txMsg <= m;
        txHasIe <= h;
        txIe <= e;
        txData <= d;
        pathActive <= pa;
        @(posedge core_clk);
        txReq <= 1'b0;
        txData <= ~d;
        #1 chk(txReject, rj);
        @(posedge core_clk);
        #1;
    endtask

    // bench plays a faulty exchange on the second link
    task automatic inject(input pmc_pkg::pmc_msg_t m, input logic [2:0] n, input pmc_pkg::pmc_ie_t e, input logic er);
        @(posedge core_clk);
        link2.dnValid <= 1'b1;
        link2.dnMsg <= m;
        link2.dnCount <= n;
        link2.dnIe <= '{default: e};
        link2.dnData <= 32'h0000_1111;
        @(posedge core_clk);
        link2.dnValid <= 1'b0;
        link2.dnData <= 32'hFFFF_EEEE;
        #1 chk(protoError2, er);
    endtask

    task automatic pulse(input int k, input logic [7:0] v);
        @(posedge core_clk);
        anomLine <= (k == 0);
        lineInfoReq <= (k == 1);
        pulseEvent <= (k == 2);
        portStatusReq <= (k == 3);
        lineInfoPar <= v[2:0];
        portStatus <= v;
        @(posedge core_clk);
        {anomLine, lineInfoReq, pulseEvent, portStatusReq} <= 4'h0;
        portStatus <= ~v;
    endtask

    task automatic waitRx(input pmc_pkg::pmc_msg_t m, input pmc_pkg::pmc_ie_t e, input logic [7:0] d);
        int i = 0;
        while (rxValid !== 1'b1 && i < 6) begin
            @(posedge core_clk);
            #1 i++;
        end
        chk({rxValid, rxError, rxHasIe}, 3'h5);
        chk({rxMsg, rxIe, rxData}, {m, e, d});
    endtask

    task automatic quiet(input logic [15:0] sig);
        repeat (4) begin
            @(posedge core_clk);
            #1 chk(rxValid, sig);
        end
    endtask

    always #20 core_clk = ~core_clk;

    // a hang ends the run as a failure
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            summarize();
        end
    end

    initial begin
        link2.dnValid = 1'b0;
        link2.dnMsg = pmc_pkg::MSG_OTHER;
        link2.dnCount = 3'h0;
        link2.dnIe = '{default: pmc_pkg::IE_LINE_INFO};
        link2.dnData = '0;
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'b0;
        #1 chk(pathState, pmc_pkg::PATH_NULL);
        send(pmc_pkg::MSG_PROTOCOL_PARAM, 1'b1, pmc_pkg::IE_RECOG_TIME, 8'h21, 1'b0, 1'b1);
        send(pmc_pkg::MSG_ESTABLISH, 1'b1, pmc_pkg::IE_DIGIT, 8'h00, 1'b0, 1'b1);
        send(pmc_pkg::MSG_ESTABLISH, 1'b1, pmc_pkg::IE_LINE_INFO, 8'h08, 1'b0, 1'b1);
        send(pmc_pkg::MSG_ESTABLISH, 1'b1, pmc_pkg::IE_STEADY, 8'h12, 1'b0, 1'b0);
        chk({protoError, pathState}, {1'b0, pmc_pkg::PATH_ACTIVE});
        send(pmc_pkg::MSG_ESTABLISH_ACK, 1'b1, pmc_pkg::IE_CAD_RING, 8'h00, 1'b1, 1'b1);
        send(pmc_pkg::MSG_SIGNAL, 1'b1, pmc_pkg::IE_LINE_INFO, 8'h00, 1'b1, 1'b1);
        send(pmc_pkg::MSG_SIGNAL, 1'b1, pmc_pkg::IE_SEQ_RESP, 8'h00, 1'b1, 1'b1);
        send(pmc_pkg::MSG_SIGNAL, 1'b1, pmc_pkg::IE_DIGIT, 8'h35, 1'b1, 1'b0);
        chk({sigValid, sigIe, sigData}, {1'b1, pmc_pkg::IE_DIGIT, 8'h35});
        send(pmc_pkg::MSG_SIGNAL, 1'b1, pmc_pkg::IE_AUTO_SEQ, 8'h09, 1'b1, 1'b0);
        chk({seqStart, seqType}, {1'b1, 4'h9});
        send(pmc_pkg::MSG_PROTOCOL_PARAM, 1'b1, pmc_pkg::IE_DIGIT, 8'h00, 1'b1, 1'b1);
        for (int i = 0; i < 3; i++) begin
            send(pmc_pkg::MSG_PROTOCOL_PARAM, 1'b1, pp[i], {6'h08, i[1:0]}, 1'b1, 1'b0);
            chk({paramValid, paramIe, paramData}, {1'b1, pp[i], 6'h08, i[1:0]});
        end
        quiet(16'h0000);
        send(pmc_pkg::MSG_DISCONNECT, 1'b1, pmc_pkg::IE_DIGIT, 8'h00, 1'b1, 1'b1);
        send(pmc_pkg::MSG_DISCONNECT, 1'b1, pmc_pkg::IE_STEADY, 8'h07, 1'b1, 1'b0);
        chk({portDeactivate, pathState}, {1'b1, pmc_pkg::PATH_DISC});
        send(pmc_pkg::MSG_DISCONNECT, 1'b0, pmc_pkg::IE_STEADY, 8'h00, 1'b1, 1'b0);
        chk({portDeactivate, protoError}, 2'h0);
        send(pmc_pkg::MSG_DISC_COMPLETE, 1'b1, pmc_pkg::IE_DIGIT, 8'h00, 1'b0, 1'b1);
        send(pmc_pkg::MSG_DISC_COMPLETE, 1'b1, pmc_pkg::IE_STEADY, 8'h44, 1'b0, 1'b0);
        chk({applySteady, steadyCode, pathState}, {1'b1, 8'h44, pmc_pkg::PATH_NULL});
        send(pmc_pkg::MSG_SIGNAL, 1'b1, pmc_pkg::IE_AUTO_SEQ, 8'h03, 1'b0, 1'b1);
        send(pmc_pkg::MSG_ESTABLISH_ACK, 1'b1, pmc_pkg::IE_PULSED, 8'h01, 1'b1, 1'b0);
        chk(pathState, pmc_pkg::PATH_ACTIVE);
        pulse(0, 8'h00);
        waitRx(pmc_pkg::MSG_ESTABLISH, pmc_pkg::IE_LINE_INFO, 8'h04);
        for (int i = 0; i < 5; i++) begin
            pulse(1, {5'h00, i[2:0]});
            waitRx(pmc_pkg::MSG_ESTABLISH, pmc_pkg::IE_LINE_INFO, {5'h00, i[2:0]});
        end
        pulse(1, 8'h05);
        quiet(16'h0000);
        pulse(2, 8'h00);
        waitRx(pmc_pkg::MSG_SIGNAL, pmc_pkg::IE_PULSE_NOTIFY, pmc_pkg::PULSE_NOTE_VAL);
        pulse(3, 8'h5A);
        waitRx(pmc_pkg::MSG_DISCONNECT, pmc_pkg::IE_STEADY, 8'h5A);
        inject(pmc_pkg::MSG_PROTOCOL_PARAM, 3'h1, pmc_pkg::IE_RECOG_TIME, 1'b1);
        inject(pmc_pkg::MSG_SIGNAL, 3'h2, pmc_pkg::IE_DIGIT, 1'b1);
        inject(pmc_pkg::MSG_SIGNAL, 3'h1, pmc_pkg::IE_AUTO_SEQ, 1'b1);
        inject(pmc_pkg::MSG_ESTABLISH, 3'h1, pmc_pkg::IE_DIGIT, 1'b1);
        inject(pmc_pkg::MSG_SIGNAL, 3'h1, pmc_pkg::IE_SEQ_RESP, 1'b1);
        inject(pmc_pkg::MSG_PROTOCOL_PARAM, 3'h2, pmc_pkg::IE_RECOG_TIME, 1'b0);
        inject(pmc_pkg::MSG_DISCONNECT, 3'h1, pmc_pkg::IE_DIGIT, 1'b1);
        summarize();
    end
endmodule
